/* File: design/lpsq_pkg.sv */
package lpsq_pkg;
	// Register map
	localparam logic [7:0] OFF_OPCFG          = 8'h01;
	localparam logic [7:0] OFF_BAND           = 8'h03;
	localparam logic [7:0] OFF_COLOUR [3]     = '{8'h10, 8'h20, 8'h30};
	localparam logic [7:0] OFF_TIME [3]       = '{8'h19, 8'h29, 8'h39};
	localparam logic [7:0] OFF_CE [3]         = '{8'h1C, 8'h2C, 8'h3C};
	localparam logic [7:0] OFF_NEXT [3]       = '{8'h1E, 8'h2E, 8'h3E};
	localparam logic [7:0] OFF_LOOP [3]       = '{8'h1F, 8'h2F, 8'h3F};
	localparam logic [7:0] OFF_COLOUR_UPDATE  = 8'h40;
	localparam logic [7:0] OFF_START [3]      = '{8'h41, 8'h42, 8'h43};
	localparam logic [7:0] OFF_SOFT_RESET     = 8'h4F;
	localparam int         REG_STORED         = 64;
	localparam logic [7:0] MAGIC              = 8'hC5;
	localparam logic [7:0] RST_NEXT           = 8'h01;
	localparam logic [7:0] RST_CE             = 8'h01;
	localparam logic [7:0] RST_OTHER          = 8'h00;
	// Operating configuration fields
	localparam int         OPCFG_EN_BIT       = 0;
	localparam int         OPCFG_MODE_LSB     = 1;
	localparam int         OPCFG_OUT_LSB      = 4;
	localparam logic [1:0] MODE_RGW           = 2'b01;
	localparam logic [1:0] MODE_RGB           = 2'b10;
	localparam logic [1:0] GAM_35             = 2'b01;
	localparam logic [1:0] GAM_LIN            = 2'b10;
	localparam logic [1:0] NEXT_NONE          = 2'd3;
	// Arbitrary neutral bus address
	localparam logic [6:0] I2C_DEV_ADDR       = 7'h53;
	// Phase timing: durations count 10 ms ticks
	localparam int         CLK_PERIOD_NS      = 5;
	localparam int         TICK_NS            = 10_000_000;
	localparam int         TICK_CYCLES        = TICK_NS / CLK_PERIOD_NS;
	localparam logic [9:0] DUR_TICKS [16]     = '{10'd3, 10'd13, 10'd26, 10'd38, 10'd51,
		10'd77, 10'd104, 10'd160, 10'd210, 10'd260, 10'd310, 10'd420, 10'd520, 10'd620,
		10'd730, 10'd830};
	localparam logic [7:0] RAMP_STEP [16]     = '{8'd85, 8'd20, 8'd10, 8'd7, 8'd5, 8'd4,
		8'd3, 8'd2, 8'd2, 8'd1, 8'd1, 8'd1, 8'd1, 8'd1, 8'd1, 8'd1};

	function automatic logic [7:0] reg_default(input int a);
		if (a == int'(OFF_NEXT[0]) || a == int'(OFF_NEXT[1]) || a == int'(OFF_NEXT[2]))
			return RST_NEXT;
		if (a == int'(OFF_CE[0]) || a == int'(OFF_CE[1]) || a == int'(OFF_CE[2]))
			return RST_CE;
		return RST_OTHER;
	endfunction : reg_default

	// Square and cube stand in for 2.4 and 3.5; cheap, close enough visually
	function automatic logic [7:0] lpsq_curve(input logic [7:0] b, input logic [1:0] g);
		logic [15:0] sq;
		logic [23:0] cu;
		sq = b * b;
		cu = sq * b;
		if (g == GAM_LIN)
			return b;
		if (g == GAM_35)
			return cu[23:16];
		return sq[15:8];
	endfunction : lpsq_curve

	function automatic logic [1:0] lpsq_next(input logic [1:0] p, input logic [1:0] code,
		input logic [1:0] mode);
		logic grp;
		logic colour_group_mode_field;
		grp = (mode == MODE_RGB) || (mode == MODE_RGW);
		colour_group_mode_field = (mode == MODE_RGB);
		if (p == 2'd0 && code == 2'b01 && grp)
			return 2'd1;
		if (p == 2'd1 && code == 2'b01 && grp)
			return 2'd0;
		if (p == 2'd1 && code == 2'b10 && colour_group_mode_field)
			return 2'd2;
		if (p == 2'd2 && code == 2'b01 && colour_group_mode_field)
			return 2'd0;
		if (p == 2'd2 && code == 2'b10 && colour_group_mode_field)
			return 2'd1;
		return NEXT_NONE;
	endfunction : lpsq_next

	// Zero means endless
	function automatic logic [10:0] lpsq_loop_target(input logic [7:0] r);
		return r[7] ? {r[6:0], 4'b0000} : {4'b0000, r[6:0]};
	endfunction : lpsq_loop_target

	function automatic logic [4:0] lpsq_col_idx(input logic [1:0] p, input logic [1:0] c,
		input logic [1:0] o);
		return 5'(p * 9 + c * 3 + o);
	endfunction : lpsq_col_idx
endpackage : lpsq_pkg

/* File: design/lpsq_eng_if.sv */
interface lpsq_eng_if;
	logic       en;
	logic       tick;
	logic       start;
	logic       stop;
	logic [7:0] ts_t1;
	logic [7:0] t2_t3;
	logic [7:0] tp_t4;
	logic [7:0] next_cfg;
	logic [7:0] loop_cfg;
	logic [2:0] col_en;
	logic       run;
	logic       done;
	logic [7:0] bright;
	logic [1:0] col_sel;
	modport ctl (output en, tick, start, stop, ts_t1, t2_t3, tp_t4, next_cfg, loop_cfg,
		col_en, input run, done, bright, col_sel);
	modport eng (input en, tick, start, stop, ts_t1, t2_t3, tp_t4, next_cfg, loop_cfg,
		col_en, output run, done, bright, col_sel);
endinterface : lpsq_eng_if

/* File: design/lpsq_engine.sv */
module lpsq_engine (
	input wire logic ref_clk,
	input wire logic rst,
	lpsq_eng_if.eng  e
);
	typedef enum logic [2:0] {PH_IDLE, PH_START, PH_RISE, PH_HOLD, PH_FALL, PH_GAP,
		PH_OFF} lpsq_phase_t;

	lpsq_phase_t ph_r;
	logic [9:0]  cnt_r;
	logic [3:0]  pulse_r;
	logic [10:0] loops_r;
	logic [7:0]  bright_r;
	logic [1:0]  col_r;
	logic        done_r;
	logic [3:0]  code;
	logic [9:0]  dur;
	logic [7:0]  step;
	logic        ph_end;
	logic [1:0]  c1;
	logic [1:0]  c2;
	logic [1:0]  col_nxt;
	logic [1:0]  col_first;
	logic        wrap;
	logic [3:0]  rpt;
	logic [10:0] tgt;
	logic        last_pulse;
	logic        last_loop;

	// Duration code of the current phase
	assign code = (ph_r == PH_START) ? e.ts_t1[3:0] : (ph_r == PH_RISE) ? e.ts_t1[7:4] :
		(ph_r == PH_HOLD) ? e.t2_t3[3:0] : (ph_r == PH_FALL) ? e.t2_t3[7:4] :
		(ph_r == PH_GAP) ? e.tp_t4[3:0] : e.tp_t4[7:4];
	assign dur    = lpsq_pkg::DUR_TICKS[code];
	assign step   = lpsq_pkg::RAMP_STEP[code];
	assign ph_end = e.tick && (cnt_r == dur - 10'd1);
	// Next enabled colour; wrap marks one full pattern loop
	assign c1         = (col_r == 2'd2) ? 2'd0 : col_r + 2'd1;
	assign c2         = (c1 == 2'd2) ? 2'd0 : c1 + 2'd1;
	assign col_nxt    = e.col_en[c1] ? c1 : e.col_en[c2] ? c2 : col_r;
	assign wrap       = (col_nxt <= col_r);
	assign col_first  = e.col_en[0] ? 2'd0 : e.col_en[1] ? 2'd1 : e.col_en[2] ? 2'd2 : 2'd0;
	assign rpt        = e.next_cfg[7:4];
	assign tgt        = lpsq_pkg::lpsq_loop_target(e.loop_cfg);
	assign last_pulse = (rpt != 4'd0) && (pulse_r + 4'd1 == rpt);
	assign last_loop  = wrap && (tgt != 11'd0) && (loops_r + 11'd1 == tgt);

	// Phase sequencer; each phase runs out its own duration
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ph_r     <= PH_IDLE;
			cnt_r    <= 10'd0;
			pulse_r  <= 4'd0;
			loops_r  <= 11'd0;
			bright_r <= 8'd0;
			col_r    <= 2'd0;
			done_r   <= 1'b0;
		end else if (e.en) begin
			done_r <= 1'b0;
			if (e.stop) begin
				ph_r     <= PH_IDLE;
				bright_r <= 8'd0;
			end else if (e.start) begin
				ph_r     <= PH_START;
				cnt_r    <= 10'd0;
				pulse_r  <= 4'd0;
				loops_r  <= 11'd0;
				bright_r <= 8'd0;
				col_r    <= col_first;
			end else if (ph_r != PH_IDLE && e.tick) begin
				cnt_r <= ph_end ? 10'd0 : cnt_r + 10'd1;
				if (ph_r == PH_RISE)
					bright_r <= (bright_r > 8'd255 - step) ? 8'd255 : bright_r + step;
				if (ph_r == PH_FALL)
					bright_r <= (bright_r < step) ? 8'd0 : bright_r - step;
				if (ph_end) begin
					unique case (ph_r)
						PH_START, PH_GAP: ph_r <= PH_RISE;
						PH_RISE: begin
							ph_r     <= PH_HOLD;
							bright_r <= 8'd255;
						end
						PH_HOLD: ph_r <= PH_FALL;
						PH_FALL: begin
							bright_r <= 8'd0;
							pulse_r  <= last_pulse ? 4'd0 : pulse_r + 4'd1;
							ph_r     <= last_pulse ? PH_OFF : PH_GAP;
						end
						PH_OFF: begin
							col_r   <= col_nxt;
							loops_r <= wrap ? loops_r + 11'd1 : loops_r;
							ph_r    <= last_loop ? PH_IDLE : PH_RISE;
							done_r  <= last_loop;
						end
						PH_IDLE: ph_r <= PH_IDLE;
					endcase
				end
			end
		end
	end

	assign e.run     = (ph_r != PH_IDLE);
	assign e.done    = done_r;
	assign e.bright  = bright_r;
	assign e.col_sel = col_r;

	property p_endless_never_done;
		@(posedge ref_clk) disable iff (rst) done_r |-> ($past(tgt) != 11'd0);
	endproperty
	a_endless_never_done: assert property (p_endless_never_done)
		else $error("pattern finished with endless loop count");
	property p_pulse_bound;
		@(posedge ref_clk) disable iff (rst) (rpt != 4'd0 && ph_r == PH_GAP) |-> (pulse_r < rpt);
	endproperty
	a_pulse_bound: assert property (p_pulse_bound)
		else $error("pulse count passed its repeat setting");
endmodule : lpsq_engine

/* File: design/lpsq_top.sv */
module lpsq_top #(
	parameter int unsigned TICK_CYCLES = lpsq_pkg::TICK_CYCLES,
	parameter logic [6:0]  DEV_ADDR    = lpsq_pkg::I2C_DEV_ADDR
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       shutdown_n_pin,
	output logic [7:0]      out1_level,
	output logic [7:0]      out2_level,
	output logic [7:0]      out3_level,
	output logic [5:0]      out_band
);
	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_RX, I2C_RACK, I2C_TX,
		I2C_TACK} lpsq_i2c_t;
	localparam int TW = $clog2(TICK_CYCLES);

	logic        scl_s1_r, scl_s2_r, scl_s3_r;
	logic        sda_s1_r, sda_s2_r, sda_s3_r;
	logic        sdb_s1_r, sdb_s2_r, sdb_s3_r;
	lpsq_i2c_t   st_r;
	logic [2:0]  bit_r;
	logic [7:0]  sh_r;
	logic [7:0]  ptr_r;
	logic        first_r;
	logic        rw_r;
	logic        sda_oe_r;
	logic        sda_out_r;
	logic [7:0]  reg_mem_r [lpsq_pkg::REG_STORED];
	logic [7:0]  act_r [27];
	logic [7:0]  tim_r [3][3];
	logic [2:0]  start_r;
	logic [2:0]  stop_r;
	logic [1:0]  grp_r;
	logic [TW-1:0] tick_cnt_r;
	logic        tick_r;
	logic [7:0]  out_level_r [3];
	logic [5:0]  band_r;

	logic        scl_rise, scl_fall, i2c_start, i2c_stop, sdb_rise, i2c_clr;
	logic [7:0]  rx_byte;
	logic [7:0]  rd_byte;
	logic        wr_fire;
	logic [7:0]  wr_addr;
	logic        magic;
	logic        soft_rst;
	logic        store;
	logic        col_upd;
	logic [7:0]  opcfg;
	logic [1:0]  mode;
	logic        on;
	logic [2:0]  grp_mask;
	logic [2:0]  start_wr;
	logic        latch_all;
	logic [2:0]  chain_start;
	logic [2:0]  start_any;
	logic [2:0]  stop_nxt;
	logic [2:0]  pat_mode;
	logic [2:0]  run;
	logic [2:0]  done;
	logic [1:0]  nxt_pat [3];
	logic [7:0]  bright [3];
	logic [1:0]  col_sel [3];
	logic [7:0]  lvl_nxt [3];

	// Pin synchronisers; stage one feeds only stage two
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{scl_s1_r, scl_s2_r, scl_s3_r} <= 3'b111;
			{sda_s1_r, sda_s2_r, sda_s3_r} <= 3'b111;
			{sdb_s1_r, sdb_s2_r, sdb_s3_r} <= 3'b000;
		end else if (ce) begin
			{scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_in, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_in, sda_s1_r, sda_s2_r};
			{sdb_s1_r, sdb_s2_r, sdb_s3_r} <= {shutdown_n_pin, sdb_s1_r, sdb_s2_r};
		end
	end

	// Bus conditions
	assign scl_rise  = scl_s2_r & ~scl_s3_r;
	assign scl_fall  = ~scl_s2_r & scl_s3_r;
	assign i2c_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	assign i2c_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
	assign sdb_rise  = sdb_s2_r & ~sdb_s3_r;
	assign i2c_clr   = rst | (ce & sdb_rise);
	assign rx_byte   = {sh_r[6:0], sda_s2_r};
	// Offsets below 40h read back from storage, holes included; 40h and above read zero
	assign rd_byte   = (ptr_r < lpsq_pkg::OFF_COLOUR_UPDATE) ? reg_mem_r[ptr_r[5:0]] : 8'h00;

	// Serial slave; pointer auto-increments on every data byte
	always_ff @(posedge ref_clk) begin
		if (i2c_clr) begin
			st_r     <= I2C_IDLE;
			bit_r    <= 3'd0;
			sh_r     <= 8'h00;
			ptr_r    <= 8'h00;
			first_r  <= 1'b0;
			rw_r     <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (ce) begin
			if (i2c_start) begin
				st_r     <= I2C_ADDR;
				bit_r    <= 3'd0;
				first_r  <= 1'b1;
				sda_oe_r <= 1'b0;
			end else if (i2c_stop) begin
				st_r     <= I2C_IDLE;
				sda_oe_r <= 1'b0;
			end else if (scl_rise) begin
				unique case (st_r)
					I2C_IDLE: st_r <= I2C_IDLE;
					I2C_ADDR, I2C_RX: begin
						sh_r  <= rx_byte;
						bit_r <= bit_r + 3'd1;
						if (bit_r == 3'd7 && st_r == I2C_ADDR) begin
							st_r <= (rx_byte[7:1] == DEV_ADDR) ? I2C_AACK : I2C_IDLE;
							rw_r <= rx_byte[0];
						end else if (bit_r == 3'd7) begin
							st_r    <= I2C_RACK;
							first_r <= 1'b0;
							ptr_r   <= first_r ? rx_byte : ptr_r + 8'd1;
						end
					end
					I2C_AACK: begin
						bit_r <= 3'd0;
						st_r  <= rw_r ? I2C_TX : I2C_RX;
						if (rw_r) begin
							sh_r  <= rd_byte;
							ptr_r <= ptr_r + 8'd1;
						end
					end
					I2C_RACK: begin
						st_r  <= I2C_RX;
						bit_r <= 3'd0;
					end
					I2C_TX: begin
						bit_r <= bit_r + 3'd1;
						sh_r  <= {sh_r[6:0], 1'b0};
						if (bit_r == 3'd7)
							st_r <= I2C_TACK;
					end
					I2C_TACK: begin
						st_r  <= sda_s2_r ? I2C_IDLE : I2C_TX;
						bit_r <= 3'd0;
						sh_r  <= rd_byte;
						ptr_r <= sda_s2_r ? ptr_r : ptr_r + 8'd1;
					end
				endcase
			end else if (scl_fall) begin
				sda_oe_r <= (st_r == I2C_AACK) | (st_r == I2C_RACK) | ((st_r == I2C_TX) & ~sh_r[7]);
			end
		end
	end

	// Write decode; trigger offsets act only on the magic value
	assign wr_fire   = ce & scl_rise & (st_r == I2C_RX) & (bit_r == 3'd7) & ~first_r & ~sdb_rise;
	assign wr_addr   = ptr_r;
	assign magic     = (rx_byte == lpsq_pkg::MAGIC);
	assign soft_rst  = wr_fire & (wr_addr == lpsq_pkg::OFF_SOFT_RESET) & magic;
	assign store     = wr_fire & (wr_addr < lpsq_pkg::OFF_COLOUR_UPDATE);
	assign col_upd   = wr_fire & (wr_addr == lpsq_pkg::OFF_COLOUR_UPDATE) & magic;
	assign opcfg     = reg_mem_r[lpsq_pkg::OFF_OPCFG[5:0]];
	assign mode      = opcfg[lpsq_pkg::OPCFG_MODE_LSB +: 2];
	assign on        = sdb_s2_r & opcfg[lpsq_pkg::OPCFG_EN_BIT];
	assign grp_mask  = (mode == lpsq_pkg::MODE_RGB) ? 3'b111 :
		(mode == lpsq_pkg::MODE_RGW) ? 3'b011 : 3'b000;
	// Grouped outputs are forced to pattern mode
	assign pat_mode  = grp_mask | opcfg[lpsq_pkg::OPCFG_OUT_LSB +: 3];
	assign latch_all = start_wr[2] & (mode == lpsq_pkg::MODE_RGW);

	// Register file; power-on and soft reset restore defaults
	always_ff @(posedge ref_clk) begin
		if (rst || (ce && soft_rst)) begin
			for (int i = 0; i < lpsq_pkg::REG_STORED; i++)
				reg_mem_r[i] <= lpsq_pkg::reg_default(i);
		end else if (ce && store) begin
			reg_mem_r[wr_addr[5:0]] <= rx_byte;
		end
	end

	// Per-pattern engines and their chaining
	for (genvar p = 0; p < 3; p++) begin : g_pat
		lpsq_eng_if eif ();
		assign start_wr[p] = wr_fire & (wr_addr == lpsq_pkg::OFF_START[p]) & magic;
		assign nxt_pat[p]  = lpsq_pkg::lpsq_next(2'(p),
			reg_mem_r[lpsq_pkg::OFF_NEXT[p][5:0]][1:0], mode);
		assign chain_start[p] = (done[0] && nxt_pat[0] == 2'(p)) ||
			(done[1] && nxt_pat[1] == 2'(p)) || (done[2] && nxt_pat[2] == 2'(p));
		assign start_any[p] = start_wr[p] | chain_start[p];
		// A new group pattern displaces the one running
		assign stop_nxt[p]  = soft_rst | (grp_mask[p] & |(start_any & grp_mask & ~(3'b001 << p)));
		assign eif.en       = ce;
		assign eif.tick     = tick_r;
		assign eif.start    = start_r[p];
		assign eif.stop     = stop_r[p];
		assign eif.ts_t1    = tim_r[p][0];
		assign eif.t2_t3    = tim_r[p][1];
		assign eif.tp_t4    = tim_r[p][2];
		assign eif.next_cfg = reg_mem_r[lpsq_pkg::OFF_NEXT[p][5:0]];
		assign eif.loop_cfg = reg_mem_r[lpsq_pkg::OFF_LOOP[p][5:0]];
		assign eif.col_en   = reg_mem_r[lpsq_pkg::OFF_CE[p][5:0]][2:0];
		assign run[p]       = eif.run;
		assign done[p]      = eif.done;
		assign bright[p]    = eif.bright;
		assign col_sel[p]   = eif.col_sel;
		lpsq_engine u_eng (
			.ref_clk (ref_clk),
			.rst     (rst),
			.e       (eif)
		);
	end

	// Shadowed colours and timing, start and stop pulses
	always_ff @(posedge ref_clk) begin
		if (rst || (ce && soft_rst)) begin
			for (int i = 0; i < 27; i++)
				act_r[i] <= 8'h00;
			for (int p = 0; p < 3; p++)
				for (int k = 0; k < 3; k++)
					tim_r[p][k] <= 8'h00;
			start_r <= 3'b000;
			stop_r  <= rst ? 3'b000 : 3'b111;
			grp_r   <= 2'd0;
		end else if (ce) begin
			start_r <= start_any;
			stop_r  <= stop_nxt;
			for (int p = 0; p < 3; p++) begin
				if (start_any[p] && grp_mask[p])
					grp_r <= 2'(p);
				if (start_wr[p] || latch_all)
					for (int k = 0; k < 3; k++)
						tim_r[p][k] <= reg_mem_r[6'(lpsq_pkg::OFF_TIME[p] + 8'(k))];
				if (col_upd)
					for (int i = 0; i < 9; i++)
						act_r[p * 9 + i] <= reg_mem_r[6'(lpsq_pkg::OFF_COLOUR[p] + 8'(i))];
			end
		end
	end

	// Phase tick prescaler
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (ce) begin
			tick_r     <= (tick_cnt_r == TW'(TICK_CYCLES - 1));
			tick_cnt_r <= (tick_cnt_r == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
		end
	end

	// Output level per channel: pattern source, else shadowed level so 40h gates it too
	for (genvar o = 0; o < 3; o++) begin : g_out
		logic [1:0]  src;
		logic [7:0]  shade;
		logic [15:0] prod;
		assign src   = grp_mask[o] ? grp_r : 2'(o);
		assign shade = lpsq_pkg::lpsq_curve(bright[src],
			reg_mem_r[lpsq_pkg::OFF_NEXT[src][5:0]][3:2]);
		assign prod  = act_r[lpsq_pkg::lpsq_col_idx(src, col_sel[src], 2'(o))] * shade;
		assign lvl_nxt[o] = !on ? 8'h00 : pat_mode[o] ? (run[src] ? prod[15:8] : 8'h00) :
			act_r[lpsq_pkg::lpsq_col_idx(2'(o), 2'd0, 2'(o))];
	end

	// Registered outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int o = 0; o < 3; o++)
				out_level_r[o] <= 8'h00;
			band_r    <= 6'd0;
			sda_out_r <= 1'b0;
		end else if (ce) begin
			for (int o = 0; o < 3; o++)
				out_level_r[o] <= lvl_nxt[o];
			band_r    <= reg_mem_r[lpsq_pkg::OFF_BAND[5:0]][5:0];
			sda_out_r <= 1'b0;
		end
	end

	assign out1_level = out_level_r[0];
	assign out2_level = out_level_r[1];
	assign out3_level = out_level_r[2];
	assign out_band   = band_r;
	assign sda_out    = sda_out_r;
	assign sda_oe     = sda_oe_r;

	// Checks
	logic [7:0] colour0_w;
	logic [7:0] time2_w;
	assign colour0_w = reg_mem_r[lpsq_pkg::OFF_COLOUR[0][5:0]];
	assign time2_w   = reg_mem_r[lpsq_pkg::OFF_TIME[0][5:0]];

	property p_col_upd;
		@(posedge ref_clk) disable iff (rst) (col_upd) |=> (act_r[0] == $past(colour0_w));
	endproperty
	a_col_upd: assert property (p_col_upd)
		else $error("colour update did not take effect");
	property p_no_magic;
		@(posedge ref_clk) disable iff (rst)
			(wr_fire && wr_addr == lpsq_pkg::OFF_COLOUR_UPDATE && !magic) |=> $stable(act_r[0]);
	endproperty
	a_no_magic: assert property (p_no_magic)
		else $error("non-magic write changed colour state");
	property p_soft;
		@(posedge ref_clk) disable iff (rst) soft_rst |=>
			(reg_mem_r[lpsq_pkg::OFF_NEXT[0][5:0]] == lpsq_pkg::RST_NEXT) && (opcfg == 8'h00);
	endproperty
	a_soft: assert property (p_soft)
		else $error("soft reset left registers off default");
	property p_start;
		@(posedge ref_clk) disable iff (rst) start_wr[0] ##1 (ce && !stop_r[0]) |=> run[0];
	endproperty
	a_start: assert property (p_start)
		else $error("pattern 1 did not start");
	property p_rgw_latch;
		@(posedge ref_clk) disable iff (rst) latch_all |=> (tim_r[0][0] == $past(time2_w));
	endproperty
	a_rgw_latch: assert property (p_rgw_latch)
		else $error("pattern 1 timing not latched by pattern 3 update");
	property p_chain;
		@(posedge ref_clk) disable iff (rst) (ce && done[2] && !soft_rst && mode ==
			lpsq_pkg::MODE_RGB && reg_mem_r[lpsq_pkg::OFF_NEXT[2][5:0]][1:0] == 2'b10)
			|=> start_r[1];
	endproperty
	a_chain: assert property (p_chain)
		else $error("pattern 3 did not hand over to pattern 2");
	property p_single_stop;
		@(posedge ref_clk) disable iff (rst)
			(ce && done[0] && grp_mask == 3'b000 && !start_wr[1]) |=> !start_r[1];
	endproperty
	a_single_stop: assert property (p_single_stop)
		else $error("single mode chained a pattern");
	property p_sdb;
		@(posedge ref_clk) disable iff (rst) (ce && sdb_rise) |=> (st_r == I2C_IDLE) && !sda_oe;
	endproperty
	a_sdb: assert property (p_sdb)
		else $error("serial state survived shutdown rising edge");
	c_start: cover property (@(posedge ref_clk) disable iff (rst) start_wr[0] ##[1:3] run[0]);
	c_chain: cover property (@(posedge ref_clk) disable iff (rst) |chain_start);
	c_soft: cover property (@(posedge ref_clk) disable iff (rst) soft_rst);
endmodule : lpsq_top

/* File: tb/lpsq_host.sv */
module lpsq_host (
	input  wire logic ref_clk,
	input  wire logic sda_oe,
	output logic      scl_in,
	output logic      sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_r = 1'b1;
	logic sda_r = 1'b1;
	// Pulled-up open drain; SCL stands still between frames
	assign scl_in = scl_r;
	assign sda_in = sda_r & ~sda_oe;
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : hold
	// 8 cycles high, 12 low; SDA moves 4 after fall to clear the sync delay
	task automatic bit_io(input logic b, output logic s);
		sda_r <= b;
		hold(8);
		scl_r <= 1'b1;
		hold(6);
		s = sda_in;
		hold(2);
		scl_r <= 1'b0;
		hold(4);
	endtask : bit_io
	// One for start, zero for stop
	task automatic frame(input logic s);
		sda_r <= s;
		hold(4);
		scl_r <= 1'b1;
		hold(8);
		sda_r <= ~s;
		hold(8);
		scl_r <= ~s;
		hold(4);
	endtask : frame
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		logic k;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, k);
	endtask : xfer
	// Pointer, then one byte out or, on rd, one byte in
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic rd,
		output logic [7:0] q);
		frame(1'b1);
		xfer({lpsq_pkg::I2C_DEV_ADDR, 1'b0}, q);
		xfer(a, q);
		if (rd) begin
			frame(1'b1);
			xfer({lpsq_pkg::I2C_DEV_ADDR, 1'b1}, q);
		end
		xfer(d, q);
		frame(1'b0);
	endtask : acc
endmodule : lpsq_host

/* File: tb/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        shutdown_n_pin = 1'b0;
	logic        scl_in, sda_in, sda_oe, sda_out;
	logic [5:0]  out_band, band;
	logic [7:0]  out1_level, out2_level, out3_level, q, pk;
	logic [7:0]  lvl [3];
	logic [31:0] seed = 32'h8bb0_4e6b;
	int          err_total = 0;
	int          total_checks = 0;
	lpsq_top #(.TICK_CYCLES(20)) lpsq_top_inst (.ref_clk, .rst, .ce(1'b1), .scl_in, .sda_in,
		.sda_out, .sda_oe, .shutdown_n_pin, .out1_level, .out2_level, .out3_level,
		.out_band);
	lpsq_host lpsq_host_inst (.ref_clk, .sda_oe, .scl_in, .sda_in);
	// 200 MHz
	initial forever #2.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Full-scale colour times curved full brightness
	function automatic logic [7:0] peak(input int g);
		int b = (g == 2) ? 255 : (g == 1) ? (255 ** 3) >> 16 : (255 * 255) >> 8;
		return 8'((255 * b) >> 8);
	endfunction : peak
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		lpsq_host_inst.acc(a, d, 1'b0, q);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		lpsq_host_inst.acc(a, 8'hFF, 1'b1, q);
		chk(q, exp);
	endtask : rd_chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// Hang guard
	initial begin
		repeat (90000) @(posedge ref_clk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		// Defaults, unmapped place reads zero
		for (int i = 0; i < 3; i++) begin
			rd_chk(8'h1E + 8'(16 * i), 8'h01);
			rd_chk(8'h1F + 8'(16 * i), 8'h00);
		end
		rd_chk(8'h50, 8'h00);
		$display("test defaults done");
		// Level mode set up while the pin still holds shutdown
		seed = lfsr(seed);
		band = seed[5:0];
		wr(8'h03, {2'b00, band});
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			lvl[i] = seed[15:8];
			wr(8'h10 + 8'(17 * i), lvl[i]);
		end
		rd_chk(8'h21, lvl[1]);
		chk(out1_level, 8'h00);
		wr(8'h01, 8'h00);
		repeat (2000) @(posedge ref_clk);
		shutdown_n_pin <= 1'b1;
		repeat (2000) @(posedge ref_clk);
		wr(8'h01, 8'h01);
		chk(out1_level, 8'h00);
		wr(8'h40, lpsq_pkg::MAGIC);
		repeat (100) @(posedge ref_clk);
		chk(out1_level, lvl[0]);
		chk(out2_level, lvl[1]);
		chk(out3_level, lvl[2]);
		chk({2'b00, out_band}, {2'b00, band});
		wr(8'h4F, {1'b0, seed[22:16]});
		chk(out2_level, lvl[1]);
		// New level without the magic update must not show
		wr(8'h21, ~lvl[1]);
		wr(8'h40, {1'b0, seed[14:8]});
		chk(out2_level, lvl[1]);
		wr(8'h4F, lpsq_pkg::MAGIC);
		repeat (4) @(posedge ref_clk);
		chk(out3_level, 8'h00);
		rd_chk(8'h32, 8'h00);
		$display("test level mode done");
		// Out1 pattern: one pulse, one loop, shortest phases
		wr(8'h01, 8'h11);
		wr(8'h10, 8'hFF);
		wr(8'h40, lpsq_pkg::MAGIC);
		wr(8'h1F, 8'h01);
		for (int g = 0; g < 4; g++) begin
			wr(8'h1E, {4'h1, 2'(g), 2'(g)});
			wr(8'h41, lpsq_pkg::MAGIC);
			pk = 8'h00;
			repeat (900) begin
				@(posedge ref_clk);
				pk = (out1_level > pk) ? out1_level : pk;
			end
			chk(pk, peak(g));
			chk(out1_level, 8'h00);
		end
		$display("test pattern done");
		// Group modes: 43h in RG+W latches all, then pattern 3 hands over to 2 in COLOUR_GROUP_MODE_FIELD
		seed = lfsr(seed);
		wr(8'h2E, 8'h18);
		wr(8'h3E, 8'h12);
		wr(8'h2F, 8'h01);
		wr(8'h3F, 8'h01);
		wr(8'h20, 8'hFF);
		wr(8'h40, lpsq_pkg::MAGIC);
		wr(8'h19, seed[7:0]);
		wr(8'h01, 8'h03);
		wr(8'h43, lpsq_pkg::MAGIC);
		wr(8'h01, 8'h05);
		wr(8'h43, lpsq_pkg::MAGIC);
		pk = 8'h00;
		repeat (900) begin
			@(posedge ref_clk);
			pk = (out1_level > pk) ? out1_level : pk;
		end
		chk(pk, peak(2));
		chk(out1_level, 8'h00);
		chk({7'h00, sda_out}, 8'h00);
		$display("test group mode done");
		tally_and_finish();
	end
endmodule : tb
